// ---- core/pmsm_port.sv ----
// One management serial port: prescaler, frame shifter and read capture
`timescale 1ns/1ps
`default_nettype none
module pmsm_port
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [pmsm_pkg::DIV_W-1:0] divider,
  input wire logic start,
  input wire pmsm_pkg::pmsm_cmd_s cmd,
  input wire logic mdio_i,
  output pmsm_pkg::pmsm_pins_s pins,
  output logic busy,
  output logic [15:0] read_data,
  output logic done
);
  typedef enum logic [2:0] {
    PMSM_IDLE = 3'b001,
    PMSM_LOW = 3'b010,
    PMSM_HIGH = 3'b100
  } pmsm_state_e;

  pmsm_state_e state;
  logic [pmsm_pkg::DIV_W-1:0] tick_cnt;
  logic [5:0] bit_pos;
  logic [pmsm_pkg::FRAME_BITS-1:0] shifter;
  logic is_read;
  logic half_done;
  logic [5:0] next_pos;

  assign half_done = (tick_cnt == divider);
  assign next_pos = bit_pos + 6'd1;

  // Frame image: preamble, start, op, phy, reg, turnaround, data, MSB first
  function automatic logic [pmsm_pkg::FRAME_BITS-1:0] build_frame(input pmsm_pkg::pmsm_cmd_s c);
    logic [1:0] op;
    op = c.read ? pmsm_pkg::OP_READ : pmsm_pkg::OP_WRITE;
    build_frame = {32'hFFFF_FFFF, pmsm_pkg::START_PATTERN, op, c.phy_select_field,
                   c.phy_register_index_field, pmsm_pkg::TA_WRITE, c.phy_value_field};
  endfunction

  // Prescaler: each MDC half period lasts divider+1 core cycles
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= '0;
    else if (state == PMSM_IDLE || half_done)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1; // see RL3
  end

  // Sequencer: MDIO changes with the falling edge, PHY samples on rising
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= PMSM_IDLE;
      bit_pos <= '0;
      shifter <= '0;
      is_read <= 1'b0;
      pins <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        PMSM_IDLE:
        begin
          pins.mdc <= 1'b0;
          pins.mdio_oe <= 1'b0; // see RL4
          pins.mdio_o <= 1'b0;
          if (start)
          begin
            state <= PMSM_LOW; // see RL5
            shifter <= build_frame(cmd); // see RL8, RL13
            is_read <= cmd.read;
            bit_pos <= '0;
            busy <= 1'b1; // see RL14
            pins.mdio_oe <= 1'b1; // see RL6
            pins.mdio_o <= 1'b1;
          end
        end
        PMSM_LOW:
          if (half_done)
          begin
            state <= PMSM_HIGH;
            pins.mdc <= 1'b1;
          end
        PMSM_HIGH:
          if (half_done)
          begin
            pins.mdc <= 1'b0;
            if (bit_pos == 6'(pmsm_pkg::POS_LAST))
            begin
              state <= PMSM_IDLE;
              busy <= 1'b0;
              done <= 1'b1;
              pins.mdio_oe <= 1'b0;
            end
            else
            begin
              state <= PMSM_LOW;
              bit_pos <= next_pos;
              shifter <= {shifter[pmsm_pkg::FRAME_BITS-2:0], 1'b0};
              pins.mdio_o <= shifter[pmsm_pkg::FRAME_BITS-2]; // see RL7, RL11
              // Read frames hand the line to the PHY from the first turnaround bit
              pins.mdio_oe <= !(is_read && next_pos >= 6'(pmsm_pkg::POS_TA1)); // see RL9, RL10, RL12
            end
          end
        default:
          state <= PMSM_IDLE;
      endcase
    end
  end

  // Capture read data on rising MDC during the data field
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      read_data <= pmsm_pkg::DATA_RESET;
    else if (state == PMSM_LOW && half_done && is_read && bit_pos >= 6'(pmsm_pkg::POS_DATA))
      read_data <= {read_data[14:0], mdio_i}; // see RL10, RL14
  end
endmodule
`default_nettype wire

// ---- include/pmsm_pkg.sv ----
// Package with constants and carrier types for the management serial master
package pmsm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned MAX_PHYS = 32;
  localparam int unsigned PREAMBLE_BITS = 32;
  localparam int unsigned FRAME_BITS = 64;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned MDC_MIN_HZ = 290_000;
  localparam int unsigned MDC_MAX_HZ = 12_500_000;
  // Half period in core cycles is divider + 1; full period is 2*(divider + 1)
  localparam int unsigned DIV_MIN = CLK_HZ / (2 * MDC_MAX_HZ) - 1;
  localparam int unsigned DIV_MAX = CLK_HZ / (2 * MDC_MIN_HZ) - 1;
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h27;
  localparam logic [1:0] START_PATTERN = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] TA_WRITE = 2'b10;
  // Bit positions counted from the first preamble bit
  localparam int unsigned POS_TA1 = 46;
  localparam int unsigned POS_TA2 = 47;
  localparam int unsigned POS_DATA = 48;
  localparam int unsigned POS_LAST = 63;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  typedef struct packed {
    logic read;
    logic [4:0] phy_select_field;
    logic [4:0] phy_register_index_field;
    logic [15:0] phy_value_field;
  } pmsm_cmd_s;

  typedef struct packed {
    logic mdc;
    logic mdio_o;
    logic mdio_oe;
  } pmsm_pins_s;
endpackage

// ---- core/pmsm_top.sv ----
// Two-port management serial master with command, data and divider ports
//
// Operation
// RL1 - Two independent ports exist, each addressing up to 32 PHYs on its own clock and data.
// RL2 - The management clock rate is set by a software divider spanning 290 kHz to 12.5 MHz.
// RL3 - Each port derives its own clock output from the core clock through a prescaler.
// RL4 - The data line driver is released whenever no frame is running.
// RL5 - A command write launches one frame on the selected port.
// RL6 - Each frame opens with 32 preamble bits of one.
// RL7 - The start pattern 01 follows the preamble directly.
// RL8 - Op code, PHY address, register address and data follow in that order.
// RL9 - Two turnaround bits separate the register address from the data.
// RL10 - On reads the line is released in turnaround and the PHY drives zero then data.
// RL11 - On writes the master drives one then zero in turnaround and keeps driving data.
// RL12 - The shared data line is driven only by the party the frame position assigns.
// RL13 - The op code is 10 for read and 01 for write, fields are sent MSB first.
// RL14 - Busy shows from the command to the last data bit and read data is stored.
`timescale 1ns/1ps
`default_nettype none
module pmsm_top
#(
  parameter int unsigned PORTS = pmsm_pkg::NUM_PORTS
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [pmsm_pkg::DIV_W-1:0] mgmt_clock_divider_reg,
  input wire logic mgmt_command_reg_wr,
  input wire logic mgmt_command_port,
  input wire pmsm_pkg::pmsm_cmd_s mgmt_command_reg,
  input wire logic [1:0] mdio_i,
  output logic [1:0] mdc,
  output logic [1:0] mdio_o,
  output logic [1:0] mdio_oe,
  output logic [1:0] busy,
  output logic [1:0] done,
  output logic [15:0] mgmt_data_reg_p0,
  output logic [15:0] mgmt_data_reg_p1
);
  if (PORTS != 2)
  begin : g_bad_ports
    $error("pmsm_top supports exactly two ports");
  end

  logic [pmsm_pkg::DIV_W-1:0] divider;
  logic [1:0] start;
  pmsm_pkg::pmsm_pins_s pins [2];
  logic [15:0] rdata [2];
  logic [1:0] port_busy;
  logic [1:0] port_done;

  // Divider is clamped so the clock stays within its legal range
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      divider <= pmsm_pkg::DIV_RESET;
    else if (port_busy == 2'b00)
    begin
      if (mgmt_clock_divider_reg < pmsm_pkg::DIV_W'(pmsm_pkg::DIV_MIN))
        divider <= pmsm_pkg::DIV_W'(pmsm_pkg::DIV_MIN); // see RL2
      else if (mgmt_clock_divider_reg > pmsm_pkg::DIV_W'(pmsm_pkg::DIV_MAX))
        divider <= pmsm_pkg::DIV_W'(pmsm_pkg::DIV_MAX); // see RL2
      else
        divider <= mgmt_clock_divider_reg;
    end
  end

  // A command to a busy port is dropped rather than corrupting its frame
  always_comb
  begin
    start = 2'b00;
    if (mgmt_command_reg_wr && !port_busy[mgmt_command_port])
      start[mgmt_command_port] = 1'b1; // see RL5
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_port
    pmsm_port u_port
    (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .divider(divider),
      .start(start[i]),
      .cmd(mgmt_command_reg),
      .mdio_i(mdio_i[i]),
      .pins(pins[i]),
      .busy(port_busy[i]),
      .read_data(rdata[i]),
      .done(port_done[i])
    ); // see RL1, RL3
    assign mdc[i] = pins[i].mdc;
    assign mdio_o[i] = pins[i].mdio_o;
    assign mdio_oe[i] = pins[i].mdio_oe; // see RL4, RL12
    assign busy[i] = port_busy[i];
    assign done[i] = port_done[i];
  end

  assign mgmt_data_reg_p0 = rdata[0];
  assign mgmt_data_reg_p1 = rdata[1];
endmodule
`default_nettype wire

// ---- tb/pmsm_properties.sv ----
// Checker on the top-level ports of the management serial master
`timescale 1ns/1ps
`default_nettype none
module pmsm_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic mgmt_command_reg_wr,
  input wire logic mgmt_command_port,
  input wire logic [1:0] mdc,
  input wire logic [1:0] mdio_o,
  input wire logic [1:0] mdio_oe,
  input wire logic [1:0] busy,
  input wire logic [1:0] done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Idle ports do not drive the line, and idle port 0 also does not toggle its clock
  idle_release_a: assert property (!busy[0] |-> !mdio_oe[0] && !mdc[0])
    else $error("port 0 active while idle");
  idle_port1_a: assert property (!busy[1] |-> !mdio_oe[1])
    else $error("port 1 drives while idle");
  start_busy_a: assert property (mgmt_command_reg_wr && !mgmt_command_port && !busy[0]
    |=> busy[0])
    else $error("command did not start port 0");
  own_start_a: assert property ($rose(busy[0])
    |-> $past(mgmt_command_reg_wr) && !$past(mgmt_command_port))
    else $error("port 0 started without its command");
  preamble_one_a: assert property ($rose(busy[0]) |-> (mdio_oe[0] && mdio_o[0])[*8])
    else $error("frame does not open with ones");
  // Half period is at least the clamped minimum of four core cycles
  mdc_high_a: assert property ($rose(mdc[1]) |-> mdc[1][*4])
    else $error("management clock high too short");
  done_pulse_a: assert property (done[1] |=> !done[1])
    else $error("done longer than one cycle");
  busy_end_a: assert property ($fell(busy[0]) |-> done[0] || $past(done[0]))
    else $error("busy dropped without done");
endmodule
bind pmsm_top pmsm_properties i_pmsm_properties (.*);
`default_nettype wire

// ---- tb/pmsm_phy_model.sv ----
// Behavioural PHY on one port: records frames and answers reads
`timescale 1ns/1ps
`default_nettype none
module pmsm_phy_model (
  input wire logic clk_sys,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic [15:0] rdata,
  output logic mdio_i,
  output logic [63:0] frame,
  output logic clash
);
  logic mdc_q = 1'b0;
  logic drv = 1'b0;
  logic val = 1'b0;
  logic [6:0] cnt = 7'h00;
  logic [63:0] seen = '0;
  logic hit = 1'b0;
  // One process owns each recorded value, the ports only mirror it
  assign frame = seen;
  assign clash = hit;
  // Released line shows the inverse of its last bit, never a stale copy
  assign mdio_i = mdio_oe ? mdio_o : (drv ? val : ~frame[0]);
  // Sample at each rising clock, change the line just after it
  always @(posedge clk_sys)
  begin
    mdc_q <= mdc;
    hit <= hit | (mdio_oe & drv);
    if (mdc && !mdc_q)
    begin
      seen <= {seen[62:0], mdio_i};
      cnt <= (cnt == 7'h3f) ? 7'h00 : cnt + 7'h01;
      drv <= (cnt == 7'h2e) ? (seen[11:10] == 2'b10) : (drv && cnt != 7'h3f);
      val <= (cnt == 7'h2e) ? 1'b0 : rdata[4'(7'h3e - cnt)];
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the two-port management serial master
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [63:0] ta_mask = 64'h0000_0000_0002_0000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [pmsm_pkg::DIV_W-1:0] div = 8'h03;
  logic wr = 1'b0;
  logic port = 1'b0;
  pmsm_pkg::pmsm_cmd_s cmd = '0;
  logic [1:0] mdio_i, mdc, mdio_o, mdio_oe, busy, done, clash;
  logic [15:0] d0, d1;
  logic [63:0] f0, f1;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  pmsm_top i_pmsm_top (.clk_sys(clk_sys), .rst_n(rst_n), .mgmt_clock_divider_reg(div),
    .mgmt_command_reg_wr(wr), .mgmt_command_port(port), .mgmt_command_reg(cmd),
    .mdio_i(mdio_i), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .busy(busy),
    .done(done), .mgmt_data_reg_p0(d0), .mgmt_data_reg_p1(d1));
  pmsm_phy_model pm0 (.clk_sys(clk_sys), .mdc(mdc[0]), .mdio_o(mdio_o[0]),
    .mdio_oe(mdio_oe[0]), .rdata(16'ha5c3), .mdio_i(mdio_i[0]), .frame(f0), .clash(clash[0]));
  pmsm_phy_model pm1 (.clk_sys(clk_sys), .mdc(mdc[1]), .mdio_o(mdio_o[1]),
    .mdio_oe(mdio_oe[1]), .rdata(16'h3c5a), .mdio_i(mdio_i[1]), .frame(f1), .clash(clash[1]));
  always #5 clk_sys = ~clk_sys;
  // Cut a hang short
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      conclude();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Expected line image; the released first turnaround bit is masked
  function automatic logic [63:0] fr(input pmsm_pkg::pmsm_cmd_s c, input logic [15:0] r);
    fr = {32'hffff_ffff, 2'b01, c.read ? 2'b10 : 2'b01, c.phy_select_field,
      c.phy_register_index_field, 2'b10, c.read ? r : c.phy_value_field} | ta_mask;
  endfunction
  task automatic issue(input logic p, input pmsm_pkg::pmsm_cmd_s c);
    @(posedge clk_sys);
    port <= p;
    cmd <= c;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic wait_done(input int p, output int k);
    k = 1;
    while (done[p] !== 1'b1 && k < 30000)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask
  task automatic t_idle();
    #1;
    check({busy, mdio_oe, mdc, done, mdio_o, d0, d1}, '0);
  endtask
  // Writes at both clamped ends, at the minimum and at a larger divider setting
  task automatic t_div();
    logic [7:0] v [4] = '{8'hff, 8'h00, 8'h03, 8'h05};
    pmsm_pkg::pmsm_cmd_s c;
    int k;
    int e;
    foreach (v[i])
    begin
      @(posedge clk_sys);
      div <= v[i];
      c = {1'b0, 5'h1f, 5'h00, 16'h8001 ^ 16'(i)};
      issue(1'b0, c);
      wait_done(0, k);
      check(f0 | ta_mask, fr(c, 16'h0000));
      e = (v[i] < pmsm_pkg::DIV_MIN) ? pmsm_pkg::DIV_MIN :
        (v[i] > pmsm_pkg::DIV_MAX) ? pmsm_pkg::DIV_MAX : v[i];
      e = 128 * (e + 1);
      check(k > e - 3 && k < e + 3, 1'b1);
    end
  endtask
  // Read on port 0, write on port 1, a command to busy port 0, then a read on port 1
  task automatic t_pair();
    pmsm_pkg::pmsm_cmd_s a = {1'b1, 5'h00, 5'h1f, 16'hffff};
    pmsm_pkg::pmsm_cmd_s b = {1'b0, 5'h15, 5'h0a, 16'h1234};
    int k;
    issue(1'b0, a);
    issue(1'b1, b);
    issue(1'b0, b);
    wait_done(0, k);
    check(f0 | ta_mask, fr(a, 16'ha5c3));
    check(d0, 16'ha5c3);
    wait_done(1, k);
    check(f1 | ta_mask, fr(b, 16'h0000));
    issue(1'b1, a);
    wait_done(1, k);
    check(f1 | ta_mask, fr(a, 16'h3c5a));
    check(d1, 16'h3c5a);
    check(clash, 2'b00);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_idle();
    t_div();
    t_pair();
    conclude();
  end
endmodule
`default_nettype wire
